// >>> bench/adc_mode_config_port_chk.sv
`timescale 1ns/100ps
module adc_mode_config_port_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic interface_select,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input adc_mode_pkg::sample_word_t sample_in,
  input adc_mode_pkg::sample_word_t sample_out,
  input wire logic sample_out_oe,
  input adc_mode_pkg::mode_ctrl_t mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Straps pass a synchroniser, so only levels held for several edges are judged
  wire logic plain = !mode.test_pattern_en && !mode.signed_format_en && !mode.odd_bit_invert_en;
  wire logic [11:0] scr = sample_in.data ^ {{11{sample_in.data[0]}}, 1'b0};
  strap_dcs_a:
    assert property ((interface_select && $stable(cs_n))[*7] |-> mode.duty_stabilizer_en == cs_n)
    else $error("stabilizer strap ignored");
  strap_sleep_a:
    assert property ((interface_select && $stable(sck))[*7] |-> mode.sleep_en == sck)
    else $error("sleep strap ignored");
  strap_cur_a:
    assert property ((interface_select && $stable(sdi))[*7] |-> mode.drive_current_sel == {3{sdi}})
    else $error("current strap ignored");
  sdo_drain_a:
    assert property (sdo_oe |-> !sdo_o)
    else $error("serial output driven high");
  sdo_idle_a:
    assert property (cs_n && $past(cs_n) |-> !sdo_oe)
    else $error("serial output pulled outside frame");
  out_float_a:
    assert property (1'b1 |=> sample_out_oe == !$past(mode.output_disable))
    else $error("output enable wrong");
  plain_out_a:
    assert property (plain && !mode.scramble_en |=> sample_out == $past(sample_in))
    else $error("offset binary output altered");
  scramble_out_a:
    assert property (plain && mode.scramble_en |=> sample_out.data == $past(scr))
    else $error("scrambled output wrong");
  pattern_ones_a:
    assert property (mode.test_pattern_en && mode.test_pattern_sel == 3'h3 |=> sample_out == 13'h1FFF)
    else $error("all ones pattern wrong");
  drive_min_a:
    assert property (mode.drive_current_sel == 3'h7 |-> mode.drive_current_10ua == (mode.internal_term_en ? 10'h15E : 10'h0AF))
    else $error("lowest drive current wrong");
  cover property (plain && mode.scramble_en);
  cover property (interface_select && mode.sleep_en);
  cover property (sdo_oe);
endmodule // adc_mode_config_port_chk

bind adc_mode_config_port adc_mode_config_port_chk chk (.mclk(mclk), .reset_n(reset_n), .sck(sck),
  .interface_select(interface_select), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
  .sample_in(sample_in), .sample_out(sample_out), .sample_out_oe(sample_out_oe), .mode(mode));

// >>> bench/spi_host.sv
`timescale 1ns/100ps
module spi_host (
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo_line
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Clock stands still between frames; sdi flips after use so stale bits never pass for data
  task automatic xfer(input logic [15:0] word, input int n, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = (i < 16) ? word[15 - i] : ~sdi;
      #62.5 sck = 1'b1;
      if (i >= 8 && i < 16) rd[15 - i] = sdo_line;
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    sdi = ~sdi;
  endtask
  task automatic strap(input logic [2:0] lv);
    {cs_n, sck, sdi} = lv;
  endtask
endmodule // spi_host

// >>> bench/tb_adc_mode_config_port.sv
`timescale 1ns/100ps
module tb_adc_mode_config_port;
  logic mclk;
  logic reset_n;
  logic interface_select;
  wire logic sck;
  wire logic cs_n;
  wire logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic sample_out_oe;
  adc_mode_pkg::sample_word_t sample_in;
  adc_mode_pkg::sample_word_t sample_out;
  adc_mode_pkg::mode_ctrl_t mode;
  // External pull-up holds the line high whenever the device lets go
  wire logic sdo_line = sdo_oe ? sdo_o : 1'b1;
  wire logic [3:0] tim = {mode.out_clock_invert, mode.out_clock_delay_sel, mode.duty_stabilizer_en};
  wire logic [4:0] strp = {mode.duty_stabilizer_en, mode.sleep_en, mode.drive_current_sel};
  int bad_count = 0;
  int tests_run = 0;
  logic [7:0] rd;
  logic [12:0] s1;
  logic [12:0] s2;
  logic [9:0] cur [8] = '{10'h15E, 10'h190, 10'h1C2, 10'h000, 10'h12C, 10'h0FA, 10'h0D2, 10'h0AF};
  logic [7:0] ftab [10] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h13, 8'h24, 8'h77, 8'h04, 8'hA4, 8'hE4};
  spi_host host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));
  adc_mode_config_port DUT (.mclk(mclk), .reset_n(reset_n), .sck(sck), .interface_select(interface_select),
    .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sample_in(sample_in), .sample_out(sample_out),
    .sample_out_oe(sample_out_oe), .mode(mode));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Eight mclk cover the synchroniser and mode register after the last edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
    host.xfer({1'b0, a, d}, n, rd);
    repeat (8) @(negedge mclk);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    host.xfer({1'b1, a, 8'hA5}, 16, rd);
    chk("readback", exp, rd);
    @(negedge mclk);
  endtask
  function automatic logic [12:0] exp_fmt(input logic [12:0] s, input logic [7:0] f);
    logic [11:0] d;
    d = s[11:0];
    if (f[2] && f[7:5] == 3'h1) return 13'h0000;
    if (f[2] && f[7:5] == 3'h3) return 13'h1FFF;
    if (f[0]) d[11] = ~d[11];
    if (f[1]) d[11:1] = d[11:1] ^ {11{d[0]}};
    if (f[4]) d = d ^ 12'hAAA;
    return {s[12], d};
  endfunction
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end
  initial begin
    reset_n = 1'b0;
    interface_select = 1'b0;
    sample_in = 13'h1A53;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    chk("outputs on", 16'h1, sample_out_oe);
    wr(7'h00, 8'h80, 16);
    wr(7'h01, 8'hFC, 16);
    rdchk(7'h01, 8'h0C);
    chk("power", 16'h3, {mode.sleep_en, mode.nap_en});
    for (int k = 0; k < 8; k++) begin
      wr(7'h02, {4'h0, k[2:0], 1'b1}, 16);
      chk("timing", {k[2:0], 1'b1}, tim);
    end
    wr(7'h02, 8'hF0, 16);
    rdchk(7'h02, 8'h00);
    chk("stabilizer", 16'h0, mode.duty_stabilizer_en);
    for (int c = 0; c < 16; c++) begin
      wr(7'h03, {3'h0, c[2:0], c[3], 1'b0}, 16);
      chk("current", {6'h00, cur[c[2:0]]} << c[3], mode.drive_current_10ua);
      chk("termination", c[3], mode.internal_term_en);
    end
    wr(7'h03, 8'hFF, 16);
    rdchk(7'h03, 8'h1F);
    chk("output float", 16'h0, sample_out_oe);
    wr(7'h00, 8'h80, 16);
    chk("outputs back", 16'h1, sample_out_oe);
    wr(7'h05, 8'h3C, 16);
    for (int a = 0; a < 6; a++) rdchk(a[6:0], 8'h00);
    foreach (ftab[i]) begin
      sample_in = 13'h1A53 ^ {i[2:0], 10'h000};
      wr(7'h04, ftab[i], 16);
      rdchk(7'h04, ftab[i]);
      s1 = sample_out;
      @(negedge mclk);
      s2 = sample_out;
      if (ftab[i][2] && ftab[i][7] && ftab[i][5]) begin
        chk("alternation", 16'h1FFF, s1 ^ s2);
        chk("pattern", ftab[i][6] ? 16'h1555 : 16'h1FFF, s1[12] ? s1 : s1 ^ 13'h1FFF);
      end
      else chk("format", exp_fmt(sample_in, ftab[i]), s1);
    end
    wr(7'h01, 8'h08, 10);
    rdchk(7'h01, 8'h00);
    wr(7'h01, 8'h08, 20);
    rdchk(7'h01, 8'h08);
    rdchk(7'h01, 8'h08);
    interface_select = 1'b1;
    for (int p = 0; p < 8; p++) begin
      host.strap(p[2:0]);
      repeat (10) @(negedge mclk);
      chk("strap", {p[2:1], {3{p[0]}}}, strp);
    end
    end_sim;
  end
endmodule // tb_adc_mode_config_port

// >>> verilog/adc_mode_config_port.sv
`timescale 1ns/100ps
`include "adc_mode_consts.svh"
// Notes on behaviour
// - Select pin high makes chip select, serial clock and data plain mode levels.
// - Strap mode: chip select level turns duty stabilizer off or on.
// - Strap mode: serial clock level high powers down whole converter.
// - Strap mode: data-in level picks 3.5 mA or 1.75 mA drive.
// - Select pin low: one 16-bit word per write, reads supported.
// - Frame from chip select fall to rise; first sixteen rising edges sampled.
// - Word is read flag, seven address bits, eight data bits, MSB first.
// - Flag low writes data; flag high shifts addressed register out.
// - Reads leave the register unchanged and ignore the data bits.
// - Serial output is open drain: pulled low or released only.
// - Bit 7 at address 0 clears all mode registers; write-only, self-clearing.
// - Power-down register: bit 3 sleep, bit 2 nap, bits 1-0 stored and read back but unused.
// - Unused upper bits of registers 1 to 3 read as zero.
// - Timing bit 3 inverts output clock polarity.
// - Timing bits 2-1 delay output clock by 0, 45, 90 or 135 degrees.
// - Timing bit 0 turns the duty stabilizer on.
// - Output mode bits 4-2 select LVDS drive current; code 011 unused.
// - Output mode bit 1 enables termination and doubles drive current.
// - Format bit 2 enables test patterns chosen by bits 7-5; bit 3 zero, though the code stores it and reads it back.
// - Format bit 4 inverts odd output bits.
// - Output disable floats the sample word outputs, overrange flag included; serial output unaffected.
// - Scrambler XORs every data bit above the LSB with the LSB.
// - Offset binary by default, two's complement when selected.
// - Test patterns override signed format, scrambler and odd-bit inversion.

module adc_mode_config_port (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic interface_select,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  input adc_mode_pkg::sample_word_t sample_in,
  output adc_mode_pkg::sample_word_t sample_out,
  output logic sample_out_oe,
  output adc_mode_pkg::mode_ctrl_t mode
);

  // Serial clock domain
  logic frame_rst_n;
  logic [4:0] bit_count;
  logic [14:0] shift;
  adc_mode_pkg::serial_word_t write_word;
  logic write_toggle;
  logic read_active;
  logic [7:0] read_data;
  logic sdo_pull;

  wire [6:0] header_addr;
  wire header_is_read;
  wire frame_open;
  wire read_capture;
  wire write_capture;
  wire sdo_window;
  adc_mode_pkg::serial_word_t full_word;

  // Master clock domain
  logic [`SYNC_WIDTH-1:0] sync1;
  logic [`SYNC_WIDTH-1:0] sync2;
  logic [`SYNC_WIDTH-1:0] sync3;
  logic [`SYNC_WIDTH-1:0] pin_level;
  logic toggle_seen;
  logic [7:0] power_down_reg;
  logic [7:0] output_clock_timing_reg;
  logic [7:0] output_driver_mode_reg;
  logic [7:0] data_format_reg;
  logic alt_phase;

  wire write_event;
  wire strap_mode;
  wire soft_reset_hit;
  wire [`SYNC_WIDTH-1:0] sync_in;
  wire hit_soft_reset;
  wire hit_power_down;
  wire hit_clock_timing;
  wire hit_driver_mode;
  wire hit_data_format;
  adc_mode_pkg::mode_ctrl_t next_mode;
  adc_mode_pkg::sample_word_t next_sample;

  function automatic logic [7:0] read_mux(input logic [6:0] addr, input logic [7:0] pd,
                                          input logic [7:0] tim, input logic [7:0] drv,
                                          input logic [7:0] fmt);
    logic [7:0] value;
    value = `REG_RESET_VALUE;
    case (addr)
      `ADDR_POWER_DOWN: value = pd & `MASK_POWER_DOWN;
      `ADDR_CLOCK_TIMING: value = tim & `MASK_CLOCK_TIMING;
      `ADDR_DRIVER_MODE: value = drv & `MASK_DRIVER_MODE;
      `ADDR_DATA_FORMAT: value = fmt & `MASK_DATA_FORMAT;
      default: value = `REG_RESET_VALUE; // Reset register is write-only
    endcase
    return value;
  endfunction

  function automatic logic [9:0] drive_current(input logic [2:0] code, input logic term);
    logic [9:0] base;
    base = `CUR_NONE;
    case (code)
      `CUR_CODE_3P5: base = `CUR_3P5;
      `CUR_CODE_4P0: base = `CUR_4P0;
      `CUR_CODE_4P5: base = `CUR_4P5;
      `CUR_CODE_3P0: base = `CUR_3P0;
      `CUR_CODE_2P5: base = `CUR_2P5;
      `CUR_CODE_2P1: base = `CUR_2P1;
      `CUR_CODE_1P75: base = `CUR_1P75;
      default: base = `CUR_NONE;
    endcase
    return term ? {base[8:0], 1'b0} : base;
  endfunction

  // Serial side: the frame itself resets this logic, so no edge is needed outside a frame
  assign frame_rst_n = reset_n & ~cs_n & ~interface_select;
  assign frame_open = bit_count < `FRAME_BITS;
  assign header_addr = {shift[5:0], sdi};
  assign header_is_read = shift[6];
  assign full_word = {shift, sdi};
  // Reply bits leave only in the data half of a read frame
  assign read_capture = bit_count == `LAST_HEADER_BIT && header_is_read;
  assign write_capture = !cs_n && !interface_select && bit_count == `LAST_FRAME_BIT
                         && !full_word.read_not_write;
  assign sdo_window = read_active && bit_count >= `FIRST_DATA_BIT && frame_open;

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_count <= 5'h00;
      shift <= 15'h0000;
    end else if (frame_open) begin
      bit_count <= bit_count + 5'h01;
      shift <= {shift[13:0], sdi};
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      read_active <= 1'b0;
      read_data <= 8'h00;
    end else if (read_capture) begin
      // Registers only change after a completed write frame, so they are stable here
      read_active <= 1'b1;
      read_data <= read_mux(header_addr, power_down_reg, output_clock_timing_reg,
                            output_driver_mode_reg, data_format_reg);
    end
  end

  // Write word and toggle live across frames, so only the global reset clears them
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      write_word <= '0;
      write_toggle <= 1'b0;
    end else if (write_capture) begin
      write_word <= full_word;
      write_toggle <= ~write_toggle;
    end
  end

  // Data leaves on the falling edge so the host samples it on the next rising edge
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_pull <= 1'b0;
    end else if (sdo_window) begin
      sdo_pull <= ~read_data[~bit_count[2:0]];
    end else begin
      sdo_pull <= 1'b0;
    end
  end

  assign sdo_o = 1'b0;
  assign sdo_oe = sdo_pull;

  // Pins and the write toggle each pass three flops; a change counts once two agree
  assign sync_in[`SYNC_SELECT] = interface_select;
  assign sync_in[`SYNC_CS] = cs_n;
  assign sync_in[`SYNC_SCK] = sck;
  assign sync_in[`SYNC_SDI] = sdi;
  assign sync_in[`SYNC_TOGGLE] = write_toggle;
  genvar g;
  generate
    for (g = 0; g < `SYNC_WIDTH; g++) begin : g_sync
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin_level[g] <= 1'b0;
        end else begin
          sync1[g] <= sync_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            pin_level[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_seen <= 1'b0;
    end else begin
      toggle_seen <= pin_level[`SYNC_TOGGLE];
    end
  end

  assign write_event = pin_level[`SYNC_TOGGLE] ^ toggle_seen;
  // One address decode per register, so a write can never land in two places
  assign hit_soft_reset = write_event && write_word.addr == `ADDR_SOFT_RESET;
  assign hit_power_down = write_event && write_word.addr == `ADDR_POWER_DOWN;
  assign hit_clock_timing = write_event && write_word.addr == `ADDR_CLOCK_TIMING;
  assign hit_driver_mode = write_event && write_word.addr == `ADDR_DRIVER_MODE;
  assign hit_data_format = write_event && write_word.addr == `ADDR_DATA_FORMAT;
  assign soft_reset_hit = hit_soft_reset && write_word.data[`SOFT_RESET_BIT];

  // Soft reset acts in one cycle, so its bit never needs storing and reads back as zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      power_down_reg <= `REG_RESET_VALUE;
    end else if (soft_reset_hit) begin
      power_down_reg <= `REG_RESET_VALUE;
    end else if (hit_power_down) begin
      power_down_reg <= write_word.data & `MASK_POWER_DOWN;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      output_clock_timing_reg <= `REG_RESET_VALUE;
    end else if (soft_reset_hit) begin
      output_clock_timing_reg <= `REG_RESET_VALUE;
    end else if (hit_clock_timing) begin
      output_clock_timing_reg <= write_word.data & `MASK_CLOCK_TIMING;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      output_driver_mode_reg <= `REG_RESET_VALUE;
    end else if (soft_reset_hit) begin
      output_driver_mode_reg <= `REG_RESET_VALUE;
    end else if (hit_driver_mode) begin
      output_driver_mode_reg <= write_word.data & `MASK_DRIVER_MODE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_format_reg <= `REG_RESET_VALUE;
    end else if (soft_reset_hit) begin
      data_format_reg <= `REG_RESET_VALUE;
    end else if (hit_data_format) begin
      data_format_reg <= write_word.data & `MASK_DATA_FORMAT;
    end
  end

  // Mode controls: straps when the select pin is high, registers otherwise
  assign strap_mode = pin_level[`SYNC_SELECT];

  always_comb begin
    next_mode = '0;
    if (strap_mode) begin
      next_mode.duty_stabilizer_en = pin_level[`SYNC_CS];
      next_mode.sleep_en = pin_level[`SYNC_SCK];
      next_mode.drive_current_sel = pin_level[`SYNC_SDI] ? `CUR_CODE_1P75 : `CUR_CODE_3P5;
    end else begin
      next_mode.sleep_en = power_down_reg[`PD_SLEEP_BIT];
      next_mode.nap_en = power_down_reg[`PD_NAP_BIT];
      next_mode.out_clock_invert = output_clock_timing_reg[`TIM_INVERT_BIT];
      next_mode.out_clock_delay_sel = output_clock_timing_reg[`TIM_DELAY_HI:`TIM_DELAY_LO];
      next_mode.duty_stabilizer_en = output_clock_timing_reg[`TIM_STABILIZER_BIT];
      next_mode.drive_current_sel = output_driver_mode_reg[`DRV_CURRENT_HI:`DRV_CURRENT_LO];
      next_mode.internal_term_en = output_driver_mode_reg[`DRV_TERM_BIT];
      next_mode.output_disable = output_driver_mode_reg[`DRV_DISABLE_BIT];
      next_mode.test_pattern_sel = data_format_reg[`FMT_PATTERN_HI:`FMT_PATTERN_LO];
      next_mode.test_pattern_en = data_format_reg[`FMT_PATTERN_EN_BIT];
      next_mode.odd_bit_invert_en = data_format_reg[`FMT_ODD_INVERT_BIT];
      next_mode.scramble_en = data_format_reg[`FMT_SCRAMBLE_BIT];
      next_mode.signed_format_en = data_format_reg[`FMT_SIGNED_BIT];
    end
    next_mode.drive_current_10ua = drive_current(next_mode.drive_current_sel, next_mode.internal_term_en);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= '0;
    end else begin
      mode <= next_mode;
    end
  end

  // Output formatter on the registered controls
  always_comb begin
    next_sample = sample_in;
    if (mode.signed_format_en) begin
      next_sample.data[`SIGN_BIT] = ~sample_in.data[`SIGN_BIT];
    end
    if (mode.scramble_en) begin
      next_sample.data[11:1] = next_sample.data[11:1] ^ {11{next_sample.data[0]}};
    end
    if (mode.odd_bit_invert_en) begin
      next_sample.data = next_sample.data ^ `ODD_BIT_MASK;
    end
    if (mode.test_pattern_en) begin
      case (mode.test_pattern_sel)
        `PAT_ALL_ZERO: next_sample = `WORD_ZEROS;
        `PAT_ALL_ONE: next_sample = `WORD_ONES;
        `PAT_ALTERNATE: next_sample = alt_phase ? `WORD_ONES : `WORD_ZEROS;
        `PAT_CHECKER: next_sample = alt_phase ? `WORD_CHECK_B : `WORD_CHECK_A;
        default: next_sample = next_sample;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alt_phase <= 1'b0;
    end else begin
      alt_phase <= ~alt_phase;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sample_out <= '0;
    end else begin
      sample_out <= next_sample;
    end
  end

  // The enable follows its control one cycle late, in step with the data it gates
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sample_out_oe <= 1'b0;
    end else begin
      sample_out_oe <= ~mode.output_disable;
    end
  end

endmodule // adc_mode_config_port

// >>> verilog/adc_mode_consts.svh
`ifndef ADC_MODE_CONSTS_SVH
`define ADC_MODE_CONSTS_SVH

// Register addresses (7-bit serial address field)
`define ADDR_SOFT_RESET 7'h00
`define ADDR_POWER_DOWN 7'h01
`define ADDR_CLOCK_TIMING 7'h02
`define ADDR_DRIVER_MODE 7'h03
`define ADDR_DATA_FORMAT 7'h04

// Register reset value and readable-bit masks
`define REG_RESET_VALUE 8'h00
`define MASK_POWER_DOWN 8'h0F
`define MASK_CLOCK_TIMING 8'h0F
`define MASK_DRIVER_MODE 8'h1F
`define MASK_DATA_FORMAT 8'hFF

// Field positions
`define SOFT_RESET_BIT 7
`define PD_SLEEP_BIT 3
`define PD_NAP_BIT 2
`define TIM_INVERT_BIT 3
`define TIM_DELAY_HI 2
`define TIM_DELAY_LO 1
`define TIM_STABILIZER_BIT 0
`define DRV_CURRENT_HI 4
`define DRV_CURRENT_LO 2
`define DRV_TERM_BIT 1
`define DRV_DISABLE_BIT 0
`define FMT_PATTERN_HI 7
`define FMT_PATTERN_LO 5
`define FMT_ODD_INVERT_BIT 4
`define FMT_PATTERN_EN_BIT 2
`define FMT_SCRAMBLE_BIT 1
`define FMT_SIGNED_BIT 0

// Serial frame
`define FRAME_BITS 5'd16
`define LAST_HEADER_BIT 5'd7
`define LAST_FRAME_BIT 5'd15
`define FIRST_DATA_BIT 5'd8

// Drive current codes and values in units of 10 uA
`define CUR_CODE_3P5 3'h0
`define CUR_CODE_4P0 3'h1
`define CUR_CODE_4P5 3'h2
`define CUR_CODE_UNUSED 3'h3
`define CUR_CODE_3P0 3'h4
`define CUR_CODE_2P5 3'h5
`define CUR_CODE_2P1 3'h6
`define CUR_CODE_1P75 3'h7
`define CUR_3P5 10'h15E
`define CUR_4P0 10'h190
`define CUR_4P5 10'h1C2
`define CUR_3P0 10'h12C
`define CUR_2P5 10'h0FA
`define CUR_2P1 10'h0D2
`define CUR_1P75 10'h0AF
`define CUR_NONE 10'h000

// Test pattern select codes
`define PAT_ALL_ZERO 3'h1
`define PAT_ALL_ONE 3'h3
`define PAT_ALTERNATE 3'h5
`define PAT_CHECKER 3'h7

// Output word patterns (overrange flag above 12 data bits)
`define WORD_ZEROS 13'h0000
`define WORD_ONES 13'h1FFF
`define WORD_CHECK_A 13'h1555
`define WORD_CHECK_B 13'h0AAA
`define ODD_BIT_MASK 12'hAAA
`define SIGN_BIT 11

// Pin synchroniser slots
`define SYNC_WIDTH 5
`define SYNC_SELECT 0
`define SYNC_CS 1
`define SYNC_SCK 2
`define SYNC_SDI 3
`define SYNC_TOGGLE 4

`endif

// >>> verilog/adc_mode_pkg.sv
package adc_mode_pkg;

  typedef struct packed {
    logic read_not_write;
    logic [6:0] addr;
    logic [7:0] data;
  } serial_word_t;

  typedef struct packed {
    logic sleep_en;
    logic nap_en;
    logic out_clock_invert;
    logic [1:0] out_clock_delay_sel;
    logic duty_stabilizer_en;
    logic [2:0] drive_current_sel;
    logic internal_term_en;
    logic [9:0] drive_current_10ua;
    logic output_disable;
    logic [2:0] test_pattern_sel;
    logic test_pattern_en;
    logic odd_bit_invert_en;
    logic scramble_en;
    logic signed_format_en;
  } mode_ctrl_t;

  typedef struct packed {
    logic overrange_flag;
    logic [11:0] data;
  } sample_word_t;

endpackage
